// ===== flash_cmd_defs.vh
// Opcode, protocol and address width constants for the serial flash command front end
`ifndef FLASH_CMD_DEFS_VH
`define FLASH_CMD_DEFS_VH
// Read opcodes, 3-byte and 4-byte forms
`define OP_READ3 8'h03
`define OP_READ4 8'h13
`define OP_FAST3 8'h0B
`define OP_FAST4 8'h0C
`define OP_DOUT3 8'h3B
`define OP_DOUT4 8'h3C
`define OP_DIO3 8'hBB
`define OP_DIO4 8'hBC
`define OP_QOUT3 8'h6B
`define OP_QOUT4 8'h6C
`define OP_QIO3 8'hEB
`define OP_QIO4 8'hEC
`define OP_QWORD 8'hE7
`define OP_DTR3 8'h0D
`define OP_DTR4 8'h0E
`define OP_DTR_DOUT 8'h3D
`define OP_DTR_DIO3 8'hBD
`define OP_DTR_DIO4 8'hBE
`define OP_DTR_QOUT 8'h6D
`define OP_DTR_QIO3 8'hED
`define OP_DTR_QIO4 8'hEE
// Write latch opcodes
`define OP_WREN 8'h06
`define OP_WRDI 8'h04
// Protocol codes
`define PROTO_EXT 2'h0
`define PROTO_DUAL 2'h1
`define PROTO_QUAD 2'h2
// Address widths in bits
`define ADDR_BITS3 6'h18
`define ADDR_BITS4 6'h20
`endif

// ===== flash_cmd.v
// Serial flash command front end: read decode, address capture, write enable latch
//
// What this block does
// - Decode 03h/13h as read and 0Bh/0Ch as fast read, 3/4-byte.
// - Decode 3Bh/3Ch dual output and BBh/BCh dual I/O fast reads.
// - Decode 6Bh/6Ch quad output, EBh/ECh quad I/O, E7h quad word read.
// - Decode 0Dh/0Eh DTR fast read, 3Dh, BDh and BEh DTR dual reads.
// - Decode 6Dh DTR quad output, EDh/EEh DTR quad I/O reads.
// - 4-byte forms accept a full 32-bit address.
// - Plain reads pick 3/4-byte address from the addr4_cfg configuration input.
// - Single-rate address bits are captured on the rising serial clock edge.
// - Read starts anywhere; address increments after every data byte.
// - Dedicated 4-byte opcodes ignore addr4_cfg; dedicated DTR opcodes ignore dtr_cfg.
// - Other reads use 4-byte or DTR only when configured.
// - Latch opcodes travel on 1, 2 or 4 lines per protocol.
// - Latch opcode without immediate deselect is not executed; latch stays.
// - Write enable sets the write enable latch.
// - Write disable clears the latch unless a protection error holds it.
// - Write enable is 06h, write disable 04h.
// - Dummy clock count comes from configuration settings.
`timescale 1ns/10ps
`include "flash_cmd_defs.vh"

module flash_cmd
(
   // Clock and reset
   input wire clk,
   input wire sys_rst,
   // Serial link pins
   input wire sclk,
   input wire sel_n,
   input wire [3:0] serial_data_lines,
   // Configuration
   input wire [1:0] proto,
   input wire addr4_cfg,
   input wire dtr_cfg,
   input wire [3:0] dummy_clocks,
   input wire prot_err,
   input wire clr_flag,
   // Data output handshake from the array side
   input wire byte_done,
   // Status and read outputs
   output reg wel,
   output reg read_active,
   output reg data_phase,
   output reg [31:0] read_addr,
   output reg [4:0] read_kind,
   output reg cmd_ignored
);

   // Sequencer states
   localparam ST_OPC = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_DUMMY = 3'h2;
   localparam ST_DATA = 3'h3;
   localparam ST_WAIT = 3'h4;
   localparam ST_IGN = 3'h5;
   // The sequencer walks opcode, address, dummy and data phases in order.
   // Any deselect seen through the synchroniser drops it back to the opcode
   // phase from wherever it stands, so a host may abandon a frame at any
   // point without leaving stale state behind. A latch opcode does not act
   // at its eighth bit: it waits in its own state for the deselect, because
   // a further clock edge inside the frame must cancel it. Unknown opcodes
   // park in their own state so nothing that follows in the frame can be
   // taken for an address or a new opcode.

   // Two-flop synchronisers; the first stage feeds only the second
   reg [5:0] sync1_reg;
   reg [5:0] sync2_reg;
   reg sclk_old_reg;
   reg [2:0] state_reg;
   reg [7:0] opc_reg;
   reg [3:0] opc_cnt_reg;
   reg [5:0] addr_left_reg;
   reg [2:0] lanes_reg;
   reg dtr_reg;
   reg [3:0] dummy_reg;
   reg latch_cmd_reg;
   reg [7:0] latch_op_reg;
   // Set when the address completes: the next falling edge still closes the
   // last address clock and must not be counted as a dummy clock
   reg skip_reg;

   wire sclk_s = sync2_reg[5];
   wire sel_s = sync2_reg[4];
   wire [3:0] dq_s = sync2_reg[3:0];
   wire rise = sclk_s & ~sclk_old_reg;
   wire fall = ~sclk_s & sclk_old_reg;
   wire [2:0] op_lanes = (proto == `PROTO_QUAD) ? 3'h4 :
                         (proto == `PROTO_DUAL) ? 3'h2 : 3'h1;

   // Shift lanes of input into a byte or address, widest first
   function [31:0] shift_in;
      input [31:0] cur;
      input [2:0] n;
      input [3:0] d;
      begin
         case (n)
            3'h4: shift_in = {cur[27:0], d};
            3'h2: shift_in = {cur[29:0], d[1:0]};
            default: shift_in = {cur[30:0], d[0]};
         endcase
      end
   endfunction

   // Read decode: {known, addr4_fixed, dtr_fixed, addr_lanes(3)}
   // Plain reads take their address lanes from the protocol, the I/O forms
   // force two or four lanes. The fixed bits mark opcodes whose address width
   // or rate ignores the configuration inputs; the others follow the
   // configuration only when it is enabled.
   function [5:0] decode;
      input [7:0] op;
      input [2:0] pl;
      begin
         case (op)
            `OP_READ3, `OP_FAST3, `OP_DOUT3, `OP_QOUT3: decode = {3'b100, pl};
            `OP_READ4, `OP_FAST4, `OP_DOUT4, `OP_QOUT4: decode = {3'b110, pl};
            `OP_DIO3: decode = {3'b100, 3'h2};
            `OP_DIO4: decode = {3'b110, 3'h2};
            `OP_QIO3, `OP_QWORD: decode = {3'b100, 3'h4};
            `OP_QIO4: decode = {3'b110, 3'h4};
            `OP_DTR3, `OP_DTR_DOUT, `OP_DTR_QOUT: decode = {3'b101, pl};
            `OP_DTR4: decode = {3'b111, pl};
            `OP_DTR_DIO3: decode = {3'b101, 3'h2};
            `OP_DTR_DIO4: decode = {3'b111, 3'h2};
            `OP_DTR_QIO3: decode = {3'b101, 3'h4};
            `OP_DTR_QIO4: decode = {3'b111, 3'h4};
            default: decode = 6'h00;
         endcase
      end
   endfunction

   // The opcode view of the pins one edge ahead, so the decision can be made
   // on the same clock as the eighth bit. The helper works on a full word;
   // only the low byte is the opcode.
   wire [31:0] opc_word = shift_in({24'h000000, opc_reg}, op_lanes, dq_s);
   wire [7:0] opc_now = opc_word[7:0];
   wire [5:0] dec = decode(opc_now, op_lanes);
   wire use4 = dec[4] | addr4_cfg;
   wire use_dtr = dec[3] | dtr_cfg;
   wire [5:0] abits = use4 ? `ADDR_BITS4 : `ADDR_BITS3;
   wire [3:0] opc_bits = {1'b0, op_lanes} + opc_cnt_reg;
   wire addr_edge = rise | (dtr_reg & fall);
   wire [5:0] addr_step = {3'h0, lanes_reg};

   // Synchronise the link pins
   // Clock, select and data share one synchroniser so they keep the same lag
   // and the data seen at a detected edge is the data that stood at that
   // edge. The trade-off is a link clock limited to a few system clocks per
   // half period. Reset holds select high so no false frame start follows.
   // The edge detector resets to the idle low level of the link clock.
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         sync1_reg <= 6'h10;
         sync2_reg <= 6'h10;
         sclk_old_reg <= 1'b0;
      end
      else
      begin
         sync1_reg <= {sclk, sel_n, serial_data_lines};
         sync2_reg <= sync1_reg;
         sclk_old_reg <= sclk_s;
      end
   end

   // Command sequencer and write enable latch
   // The latch only changes while deselected, except for a flag clear: this
   // keeps a half-sent opcode from touching it. When a latch opcode executes
   // at the same deselect as a flag clear, the opcode wins; the clear acts
   // again on the next cycle if it is still held. A protection error only
   // blocks the disable, never the enable.
   // Read outputs stand until the deselect is seen, which lets the array
   // side finish the byte it is shifting out.
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_reg <= ST_OPC;
         opc_reg <= 8'h00;
         opc_cnt_reg <= 4'h0;
         addr_left_reg <= 6'h00;
         lanes_reg <= 3'h1;
         dtr_reg <= 1'b0;
         dummy_reg <= 4'h0;
         latch_cmd_reg <= 1'b0;
         latch_op_reg <= 8'h00;
         skip_reg <= 1'b0;
         wel <= 1'b0;
         read_active <= 1'b0;
         data_phase <= 1'b0;
         read_addr <= 32'h00000000;
         read_kind <= 5'h00;
         cmd_ignored <= 1'b0;
      end
      else if (sel_s)
      begin
         // Deselect: execute a complete latch opcode, abort any read
         if (latch_cmd_reg)
         begin
            if (latch_op_reg == `OP_WREN)
               wel <= 1'b1;
            else if (!prot_err)
               wel <= 1'b0;
         end
         else if (clr_flag)
            wel <= 1'b0;
         state_reg <= ST_OPC;
         opc_cnt_reg <= 4'h0;
         latch_cmd_reg <= 1'b0;
         read_active <= 1'b0;
         data_phase <= 1'b0;
         cmd_ignored <= 1'b0;
      end
      else
      begin
         if (clr_flag)
            wel <= 1'b0;
         case (state_reg)
            ST_OPC:
               if (rise)
               begin
                  opc_reg <= opc_now;
                  opc_cnt_reg <= opc_bits;
                  if (opc_bits == 4'h8)
                  begin
                     if (opc_now == `OP_WREN || opc_now == `OP_WRDI)
                     begin
                        latch_cmd_reg <= 1'b1;
                        latch_op_reg <= opc_now;
                        state_reg <= ST_WAIT;
                     end
                     else if (dec[5])
                     begin
                        lanes_reg <= dec[2:0];
                        dtr_reg <= use_dtr;
                        addr_left_reg <= abits;
                        read_addr <= 32'h00000000;
                        read_kind <= {use4, use_dtr, dec[2:0]};
                        read_active <= 1'b1;
                        state_reg <= ST_ADDR;
                     end
                     else
                     begin
                        cmd_ignored <= 1'b1;
                        state_reg <= ST_IGN;
                     end
                  end
               end
            ST_ADDR:
               if (addr_edge)
               begin
                  read_addr <= shift_in(read_addr, lanes_reg, dq_s);
                  addr_left_reg <= addr_left_reg - addr_step;
                  if (addr_left_reg == addr_step)
                  begin
                     dummy_reg <= dummy_clocks;
                     skip_reg <= 1'b1;
                     state_reg <= (dummy_clocks == 4'h0) ? ST_DATA : ST_DUMMY;
                     data_phase <= (dummy_clocks == 4'h0);
                  end
               end
            ST_DUMMY:
               if (fall)
               begin
                  if (skip_reg)
                     skip_reg <= 1'b0; // Closes the last address clock
                  else
                  begin
                     dummy_reg <= dummy_reg - 4'h1;
                     if (dummy_reg == 4'h1)
                     begin
                        state_reg <= ST_DATA;
                        data_phase <= 1'b1;
                     end
                  end
               end
            // The array side paces the data phase; the address only moves
            // on its byte pulse, so a slow host never loses a byte. The
            // address wraps at the top of the 32-bit space.
            ST_DATA:
               if (byte_done)
                  read_addr <= read_addr + 32'h00000001;
            ST_WAIT:
               if (rise)
                  latch_cmd_reg <= 1'b0;
            ST_IGN:
               state_reg <= ST_IGN;
            default:
               state_reg <= ST_OPC;
         endcase
      end
   end

endmodule // flash_cmd

// ===== flash_cmd_assertions.sv
// Port-level checks for the flash command front end
`timescale 1ns/10ps
module flash_cmd_chk
(
   // Clock and reset
   input wire clk,
   input wire sys_rst,
   // Watched inputs
   input wire sel_n,
   input wire prot_err,
   input wire clr_flag,
   input wire byte_done,
   // Watched outputs
   input wire wel,
   input wire read_active,
   input wire data_phase,
   input wire [31:0] read_addr,
   input wire [4:0] read_kind,
   input wire cmd_ignored
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Eight cycles cover the select synchroniser lag with margin
   sequence s_idle;
      sel_n [*8];
   endsequence
   sequence s_busy;
      (!sel_n && !clr_flag) [*8];
   endsequence
   AST_DESEL: assert property (s_idle |-> !read_active && !data_phase && !cmd_ignored)
      else $error("command outlived deselect");
   AST_WEL_FRAME: assert property (s_busy |-> $stable(wel))
      else $error("latch moved inside frame");
   AST_CLR: assert property (s_idle ##1 (sel_n && clr_flag) |=> !wel)
      else $error("flag clear kept latch");
   AST_PROT: assert property (wel && prot_err && !clr_flag |=> wel)
      else $error("latch lost under protection error");
   AST_INC: assert property (data_phase && byte_done |=> read_addr == $past(read_addr) + 1)
      else $error("address did not step");
   AST_HOLD: assert property (data_phase && !byte_done ##1 data_phase |-> $stable(read_addr))
      else $error("address moved without byte");
   AST_KIND: assert property (read_active [*2] |-> $stable(read_kind))
      else $error("read kind moved in frame");
   AST_DATA: assert property (data_phase |-> read_active)
      else $error("data phase without read");
   AST_IGN: assert property (cmd_ignored |-> !read_active)
      else $error("ignored opcode started read");
endmodule // flash_cmd_chk
bind flash_cmd flash_cmd_chk i_chk (.clk(clk), .sys_rst(sys_rst), .sel_n(sel_n),
   .prot_err(prot_err), .clr_flag(clr_flag), .byte_done(byte_done), .wel(wel),
   .read_active(read_active), .data_phase(data_phase), .read_addr(read_addr),
   .read_kind(read_kind), .cmd_ignored(cmd_ignored));

// ===== spi_host.sv
// Host controller model driving link clock, select and data lines
`timescale 1ns/10ps
module spi_host
(
   // Clock
   input wire clk,
   // Link pins
   output logic sclk,
   output logic sel_n,
   output logic [3:0] dq
);
   initial
   begin
      sclk = 1'h0;
      sel_n = 1'h1;
      dq = 4'hF;
   end
   // Half link period, 800 ns period overall
   task automatic hw();
      repeat (4) @(negedge clk);
   endtask
   // Data moves mid-phase so the synchroniser never sees it with the edge
   task automatic shift(input logic [31:0] v, input int n, input int w, input bit ddr);
      for (int i = n; i > 0; i -= w)
      begin
         repeat (2) @(negedge clk);
         dq = 4'(v >> (i - w)) & 4'((1 << w) - 1);
         repeat (2) @(negedge clk);
         sclk = ~sclk;
         if (!ddr)
         begin
            hw();
            sclk = 1'h0;
         end
      end
   endtask
   // Dummy clocks with changing data
   task automatic pulses(input int n);
      repeat (n)
      begin
         hw();
         sclk = 1'h1;
         dq = dq + 4'h1;
         hw();
         sclk = 1'h0;
      end
   endtask
   // Return the link clock low, closing a clock left high
   task automatic idle();
      hw();
      sclk = 1'h0;
   endtask
   task automatic open();
      sel_n = 1'h0;
      hw();
   endtask
   // Released lines invert so stale data is never seen
   task automatic close();
      hw();
      sel_n = 1'h1;
      dq = ~dq;
      repeat (8) @(negedge clk);
   endtask
endmodule // spi_host

// ===== tb_top.sv
// Self-checking bench for the flash command front end
`timescale 1ns/10ps
module tb_top;
   logic clk = 1'h0, sys_rst = 1'h1, prot_err = 1'h0, clr_flag = 1'h0, byte_done = 1'h0;
   logic addr4_cfg = 1'h0, dtr_cfg = 1'h0, sclk, sel_n;
   logic [3:0] dq, dummy_clocks = 4'h1;
   logic [1:0] proto = 2'h0;
   wire wel, read_active, data_phase, cmd_ignored;
   wire [31:0] read_addr;
   wire [4:0] read_kind;
   int fails = 0, total_checks = 0, seed = 32'h8F0A762B, cyc = 0;
   logic [31:0] exp_a;
   // Opcode table and {4byte,dtr,lane code} per entry, entry 0 lowest
   logic [167:0] ops = 168'hEEED6DBEBD3D0E0DE7ECEB6C6BBCBB3C3B0C0B1303;
   logic [83:0] meta = 84'hE64D54C42A28091808080;
   always #50 clk = ~clk;
   spi_host i_host (.clk(clk), .sclk(sclk), .sel_n(sel_n), .dq(dq));
   flash_cmd i_dut (.clk(clk), .sys_rst(sys_rst), .sclk(sclk), .sel_n(sel_n),
      .serial_data_lines(dq), .proto(proto), .addr4_cfg(addr4_cfg), .dtr_cfg(dtr_cfg),
      .dummy_clocks(dummy_clocks), .prot_err(prot_err), .clr_flag(clr_flag),
      .byte_done(byte_done), .wel(wel), .read_active(read_active), .data_phase(data_phase),
      .read_addr(read_addr), .read_kind(read_kind), .cmd_ignored(cmd_ignored));
   task automatic complete_run();
      if (fails == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Hang guard well above the expected run length
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         fails++;
         complete_run();
      end
   end
   task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         fails++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic chk_flag(input string nm, input logic e, input logic g);
      chk_word(nm, {31'h0, e}, {31'h0, g});
   endtask
   task automatic settle();
      repeat (6) @(negedge clk);
   endtask
   task automatic rd(input int i, input bit a4, input bit dt);
      logic [3:0] m;
      logic [7:0] op;
      int n;
      bit ddr;
      m = meta[i*4+:4];
      op = ops[i*8+:8];
      ddr = m[2] | dt;
      n = (m[3] | a4) ? 32 : 24;
      exp_a = $random(seed);
      exp_a = (n == 24) ? {8'h00, exp_a[23:0]} : exp_a;
      dummy_clocks = 4'h1 + 4'($random(seed) & 3);
      i_host.open();
      if (ddr)
      begin
         // Last opcode clock stays high: its fall carries the first address bit
         i_host.shift(op >> 1, 7, 1, 1'h0);
         i_host.shift(op, 1, 1, 1'h1);
      end
      else
         i_host.shift(op, 8, 1, 1'h0);
      i_host.shift(exp_a, n, 1 << m[1:0], ddr);
      i_host.idle();
      settle();
      chk_flag("active", 1'h1, read_active);
      chk_word("addr", exp_a, read_addr);
      chk_flag("kind4", m[3] | a4, read_kind[4]);
      chk_flag("kinddtr", ddr, read_kind[3]);
      i_host.pulses(dummy_clocks - 1);
      settle();
      chk_flag("data", 1'h0, data_phase);
      i_host.pulses(1);
      settle();
      chk_flag("data", 1'h1, data_phase);
      repeat (1 + ($random(seed) & 3))
      begin
         byte_done = 1'h1;
         @(negedge clk);
         byte_done = 1'h0;
         @(negedge clk);
         exp_a++;
      end
      chk_word("addr", exp_a, read_addr);
      i_host.close();
      chk_flag("active", 1'h0, read_active);
   endtask
   task automatic latch(input logic [7:0] op, input int extra);
      i_host.open();
      i_host.shift(op, 8, 1 << proto, 1'h0);
      i_host.pulses(extra);
      i_host.close();
   endtask
   initial
   begin
      settle();
      sys_rst = 1'h0;
      settle();
      chk_flag("wel", 1'h0, wel);
      for (int i = 0; i < 21; i++)
         rd(i, 1'h0, 1'h0);
      addr4_cfg = 1'h1;
      rd(0, 1'h1, 1'h0);
      addr4_cfg = 1'h0;
      dtr_cfg = 1'h1;
      rd(0, 1'h0, 1'h1);
      dtr_cfg = 1'h0;
      for (int p = 0; p < 3; p++)
      begin
         proto = 2'(p);
         latch(8'h06, 0);
         chk_flag("wel", 1'h1, wel);
         latch(8'h04, 0);
         chk_flag("wel", 1'h0, wel);
      end
      proto = 2'h0;
      latch(8'h06, 1);
      chk_flag("wel", 1'h0, wel);
      latch(8'h06, 0);
      prot_err = 1'h1;
      latch(8'h04, 0);
      chk_flag("wel", 1'h1, wel);
      clr_flag = 1'h1;
      settle();
      clr_flag = 1'h0;
      prot_err = 1'h0;
      chk_flag("wel", 1'h0, wel);
      i_host.open();
      i_host.shift(8'hA5, 8, 1, 1'h0);
      settle();
      chk_flag("ignored", 1'h1, cmd_ignored);
      i_host.close();
      chk_flag("ignored", 1'h0, cmd_ignored);
      complete_run();
   end
endmodule // tb_top
